// ### include/caf_pkg.sv
package caf_pkg;
    // ===================================================
    // sizes
    localparam int CAF_NUM_FLT = 16;
    localparam int CAF_NUM_BUF = 32;
    localparam int CAF_NUM_BYTE = 8;
    // ===================================================
    // register word indices on the register port
    localparam logic [8:0] CAF_ADDR_SID_BASE = 9'h000;
    localparam logic [8:0] CAF_ADDR_EID_BASE = 9'h010;
    localparam logic [8:0] CAF_ADDR_FEN = 9'h020;
    localparam logic [8:0] CAF_ADDR_BPNT_BASE = 9'h021;
    localparam logic [8:0] CAF_ADDR_CTRL = 9'h025;
    localparam logic [8:0] CAF_ADDR_STAT = 9'h026;
    localparam int CAF_ADDR_BUF_BIT = 8;
    // ===================================================
    // field positions
    localparam int CAF_SID_MSB = 15;
    localparam int CAF_SID_LSB = 5;
    localparam int CAF_SID_TYPE_BIT = 3;
    localparam int CAF_SID_EIDH_MSB = 1;
    localparam logic [15:0] CAF_SID_WMASK = 16'hffeb;
    localparam int CAF_DLC_EID_LSB = 10;
    localparam int CAF_DLC_RTR_BIT = 9;
    localparam logic [15:0] CAF_DLC_WMASK = 16'hff1f;
    localparam int CAF_CTRL_MTE_BIT = 0;
    localparam int CAF_STAT_BUSY_BIT = 15;
    // ===================================================
    // word slots inside one buffer
    localparam logic [2:0] CAF_BW_ID = 3'h0;
    localparam logic [2:0] CAF_BW_EXT = 3'h1;
    localparam logic [2:0] CAF_BW_DLC = 3'h2;
    localparam logic [2:0] CAF_BW_DATA = 3'h3;
    localparam logic [3:0] CAF_MAX_DLC = 4'h8;
    // ===================================================
    // reset values
    localparam logic [15:0] CAF_FEN_RST = 16'hffff;
    localparam logic [15:0] CAF_CFG_RST = 16'h0000;

    typedef enum logic {CAF_IDLE, CAF_STORE} caf_wr_state_t;
endpackage

// ### include/caf_mem_if.sv
`timescale 1ns/100ps
interface caf_mem_if #(parameter int AW = 8, parameter int DW = 16);
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl (output en, output we, output addr, output wdata,
                  input rdata);
    modport mem  (input en, input we, input addr, input wdata,
                  output rdata);
endinterface

// ### rtl/caf_buf_mem.sv
`timescale 1ns/100ps
module caf_buf_mem
    import caf_pkg::*;
#(
    parameter int DEPTH = 256
)
(
    input  wire logic clock,
    input  wire logic rst_b,
    caf_mem_if.mem    port
);
    logic [15:0] mem_q [DEPTH];

    // no reset on the array: buffer contents are undefined until written
    always_ff @(posedge clock)
    begin
        if (port.en && port.we)
            mem_q[port.addr] <= port.wdata;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            port.rdata <= '0;
        else if (port.en && !port.we)
            port.rdata <= mem_q[port.addr];
    end
endmodule

// ### rtl/caf_match.sv
`timescale 1ns/100ps
module caf_match
    import caf_pkg::*;
#(
    parameter int NF = CAF_NUM_FLT
)
(
    input  wire logic [NF-1:0][15:0] sid_cfg,
    input  wire logic [NF-1:0][15:0] eid_cfg,
    input  wire logic [NF-1:0]       fen,
    input  wire logic                mte,
    input  wire logic                f_ide,
    input  wire logic [10:0]         f_sid,
    input  wire logic [17:0]         f_eid,
    output logic      [NF-1:0]       hit
);
    genvar g;
    generate
        for (g = 0; g < NF; g++)
        begin : g_flt
            logic sid_ok;
            logic eid_ok;
            logic type_ok;
            assign sid_ok = sid_cfg[g][CAF_SID_MSB:CAF_SID_LSB]
                            == f_sid; // [RULE3]
            assign eid_ok = {sid_cfg[g][CAF_SID_EIDH_MSB:0], eid_cfg[g]}
                            == f_eid; // [RULE8]
            // type check only when the mask asks for it
            assign type_ok = !mte // [RULE4] [RULE5]
                             || (sid_cfg[g][CAF_SID_TYPE_BIT] == f_ide);
            // extended identifier bits only count for extended frames
            assign hit[g] = fen[g] && type_ok && sid_ok // [RULE17]
                            && (!f_ide || eid_ok);
        end
    endgenerate
endmodule

// ### rtl/caf_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// (RULE1) sixteen filters 0..15, each with standard and extended id registers
// (RULE2) filter standard id compare value sits in bits 15..5
// (RULE3) every standard id bit must equal the filter bit to match
// (RULE4) type check on, filter type bit one: only extended frames match
// (RULE5) type check on, filter type bit zero: only standard frames match
// (RULE6) extended id bits 17..16 sit in bits 1..0 of standard id register
// (RULE7) extended id bits 15..0 fill the extended id register
// (RULE8) every extended id bit must equal the filter bit to match
// (RULE9) bits 4 and 2 of standard id register ignore writes, read zero
// (RULE10) thirty-two buffers 0..31, each with eight data bytes
// (RULE11) length word bits 15..10 hold the six lowest extended id bits
// (RULE12) length word bit 9 marks a remote request frame
// (RULE13) software writes zero to reserved bits 8 and 4 of length word
// (RULE14) length word bits 3..0 hold the data length code
// (RULE15) each data byte is eight bits, read and write, by buffer and byte
// (RULE16) in a shared word the upper byte is byte m+1, lower is byte m
// (RULE17) only filters with their enable bit set take part in acceptance
// (RULE18) per-filter four-bit pointer picks the receive buffer, 0000 is 0
// (RULE19) several hits accept once, lowest filter number picks the buffer
// (RULE20) length codes above eight store exactly eight data bytes
module caf_top
    import caf_pkg::*;
#(
    parameter int NF = CAF_NUM_FLT
)
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [8:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic        rx_ide,
    input  wire logic [10:0] rx_sid,
    input  wire logic [17:0] rx_eid,
    input  wire logic        rx_rtr,
    input  wire logic [3:0]  rx_dlc,
    input  wire logic [63:0] rx_data,
    output logic             rx_accept,
    output logic      [3:0]  rx_filter,
    output logic      [4:0]  rx_buffer
);
    // ===================================================
    // configuration registers
    logic [NF-1:0][15:0] sid_reg;
    logic [NF-1:0][15:0] eid_reg;
    logic [15:0]         fen_reg;
    logic [NF-1:0][3:0]  ptr_reg;
    logic                mte_reg;
    logic                wr_cfg;
    logic                buf_acc;

    assign wr_cfg = reg_wr && !reg_addr[CAF_ADDR_BUF_BIT];
    assign buf_acc = (reg_wr || reg_rd) && reg_addr[CAF_ADDR_BUF_BIT];

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            sid_reg <= '0;
            eid_reg <= '0;
        end
        else if (wr_cfg)
        begin
            for (int f = 0; f < NF; f++)
            begin
                if (reg_addr == CAF_ADDR_SID_BASE + 9'(f)) // [RULE2] [RULE6]
                    sid_reg[f] <= reg_wdata & CAF_SID_WMASK; // [RULE9]
                if (reg_addr == CAF_ADDR_EID_BASE + 9'(f))
                    eid_reg[f] <= reg_wdata; // [RULE1] [RULE7]
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            fen_reg <= CAF_FEN_RST;
            ptr_reg <= '0;
            mte_reg <= CAF_CFG_RST[CAF_CTRL_MTE_BIT];
        end
        else if (wr_cfg)
        begin
            if (reg_addr == CAF_ADDR_FEN)
                fen_reg <= reg_wdata; // [RULE17]
            if (reg_addr == CAF_ADDR_CTRL)
                mte_reg <= reg_wdata[CAF_CTRL_MTE_BIT];
            for (int j = 0; j < NF / 4; j++)
            begin
                if (reg_addr == CAF_ADDR_BPNT_BASE + 9'(j))
                begin
                    for (int i = 0; i < 4; i++)
                        ptr_reg[4*j+i] <= reg_wdata[4*i +: 4]; // [RULE18]
                end
            end
        end
    end

    // ===================================================
    // acceptance
    logic [NF-1:0] hit;
    logic [3:0]    win_flt;
    logic [3:0]    win_ptr;

    caf_match #(.NF(NF)) u_match (
        .sid_cfg (sid_reg),
        .eid_cfg (eid_reg),
        .fen     (fen_reg[NF-1:0]),
        .mte     (mte_reg),
        .f_ide   (rx_ide),
        .f_sid   (rx_sid),
        .f_eid   (rx_eid),
        .hit     (hit)
    );

    // scan from the top so the lowest hit wins
    always_comb
    begin
        win_flt = '0;
        for (int f = NF - 1; f >= 0; f--)
        begin
            if (hit[f])
                win_flt = 4'(f); // [RULE19]
        end
    end

    assign win_ptr = ptr_reg[win_flt];

    // ===================================================
    // frame capture and store sequencer
    caf_wr_state_t st_reg;
    logic [2:0]    widx_reg;
    logic [2:0]    wlast_reg;
    logic [4:0]    buf_reg;
    logic          f_ide_reg;
    logic [10:0]   f_sid_reg;
    logic [17:0]   f_eid_reg;
    logic          f_rtr_reg;
    logic [3:0]    f_dlc_reg;
    logic [63:0]   f_data_reg;
    logic          take;
    logic          wr_go;
    logic [3:0]    nbytes;

    // a frame arriving while a store is in progress waits, held off by rx_ready, until the store ends
    assign rx_ready = st_reg == CAF_IDLE;
    assign take = rx_valid && rx_ready && |hit;
    assign wr_go = st_reg == CAF_STORE && !buf_acc;
    assign nbytes = rx_dlc > CAF_MAX_DLC ? CAF_MAX_DLC : rx_dlc; // [RULE20]

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            st_reg   <= CAF_IDLE;
            widx_reg <= CAF_BW_ID;
        end
        else
        begin
            unique case (st_reg)
                CAF_IDLE:
                begin
                    if (take)
                    begin
                        st_reg   <= CAF_STORE;
                        widx_reg <= CAF_BW_ID;
                    end
                end
                CAF_STORE:
                begin
                    // software owns the memory port in any cycle it asks
                    if (wr_go)
                    begin
                        if (widx_reg == wlast_reg)
                            st_reg <= CAF_IDLE;
                        widx_reg <= widx_reg + 3'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            buf_reg    <= '0;
            wlast_reg  <= CAF_BW_DLC;
            f_ide_reg  <= 1'b0;
            f_sid_reg  <= '0;
            f_eid_reg  <= '0;
            f_rtr_reg  <= 1'b0;
            f_dlc_reg  <= '0;
            f_data_reg <= '0;
        end
        else if (take)
        begin
            buf_reg    <= {1'b0, win_ptr}; // [RULE18] [RULE19]
            wlast_reg  <= CAF_BW_DLC
                          + 3'(nbytes[3:1] + 3'(nbytes[0])); // [RULE20]
            f_ide_reg  <= rx_ide;
            f_sid_reg  <= rx_sid;
            f_eid_reg  <= rx_eid;
            f_rtr_reg  <= rx_rtr;
            f_dlc_reg  <= rx_dlc;
            f_data_reg <= rx_data;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            rx_accept <= 1'b0;
            rx_filter <= '0;
            rx_buffer <= '0;
        end
        else
        begin
            rx_accept <= take;
            if (take)
            begin
                rx_filter <= win_flt;
                rx_buffer <= {1'b0, win_ptr};
            end
        end
    end

    // ===================================================
    // buffer memory port
    caf_mem_if #(.AW(8), .DW(16)) mem_bus ();
    logic [15:0] st_word;
    logic [63:0] data_sh;

    assign data_sh = f_data_reg >> {widx_reg - CAF_BW_DATA, 4'h0};

    always_comb
    begin
        unique case (widx_reg)
            CAF_BW_ID:  st_word = {3'h0, f_sid_reg, 1'b0, f_ide_reg};
            CAF_BW_EXT: st_word = {4'h0, f_eid_reg[17:6]};
            CAF_BW_DLC: st_word = {f_eid_reg[5:0],    // [RULE11]
                                   f_rtr_reg,         // [RULE12]
                                   1'b0, 3'h0, 1'b0,  // [RULE13]
                                   f_dlc_reg};        // [RULE14]
            default:    st_word = data_sh[15:0]; // [RULE16]
        endcase
    end

    assign mem_bus.en    = buf_acc || wr_go;
    assign mem_bus.we    = buf_acc ? reg_wr : 1'b1;
    assign mem_bus.addr  = buf_acc ? reg_addr[7:0]
                                   : {buf_reg, widx_reg}; // [RULE10]
    // bits 7..5 of the length word never store a one; reserved bits 8 and 4 take software writes unmasked
    assign mem_bus.wdata = !buf_acc ? st_word
                         : reg_addr[2:0] == CAF_BW_DLC
                         ? (reg_wdata & CAF_DLC_WMASK) : reg_wdata; // [RULE15]

    caf_buf_mem #(.DEPTH(CAF_NUM_BUF * 8)) u_mem (
        .clock (clock),
        .rst_b (rst_b),
        .port  (mem_bus)
    );

    // ===================================================
    // read path: data stand in the cycle after the strobe
    logic [15:0] rdata_reg;
    logic        rd_buf_reg;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            rdata_reg  <= '0;
            rd_buf_reg <= 1'b0;
        end
        else
        begin
            rd_buf_reg <= reg_rd && reg_addr[CAF_ADDR_BUF_BIT];
            rdata_reg  <= '0;
            if (reg_rd)
            begin
                for (int f = 0; f < NF; f++)
                begin
                    if (reg_addr == CAF_ADDR_SID_BASE + 9'(f))
                        rdata_reg <= sid_reg[f]; // [RULE9]
                    if (reg_addr == CAF_ADDR_EID_BASE + 9'(f))
                        rdata_reg <= eid_reg[f];
                end
                for (int j = 0; j < NF / 4; j++)
                begin
                    if (reg_addr == CAF_ADDR_BPNT_BASE + 9'(j))
                        rdata_reg <= {ptr_reg[4*j+3], ptr_reg[4*j+2],
                                      ptr_reg[4*j+1], ptr_reg[4*j]};
                end
                if (reg_addr == CAF_ADDR_FEN)
                    rdata_reg <= fen_reg;
                if (reg_addr == CAF_ADDR_CTRL)
                    rdata_reg <= {15'h0000, mte_reg};
                if (reg_addr == CAF_ADDR_STAT)
                    rdata_reg <= {st_reg == CAF_STORE, 6'h00,
                                  rx_buffer, rx_filter};
            end
        end
    end

    assign reg_rdata = rd_buf_reg ? mem_bus.rdata : rdata_reg;

    // ===================================================
    // checks
    logic [NF-1:0] type_vec;

    always_comb
    begin
        type_vec = '0;
        for (int f = 0; f < NF; f++)
            type_vec[f] = sid_reg[f][CAF_SID_TYPE_BIT];
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_sid_reserved_zero: assert property ( // [RULE9]
        ##1 (sid_reg[0] & ~CAF_SID_WMASK) == '0
            && (sid_reg[NF-1] & ~CAF_SID_WMASK) == '0)
        else $error("reserved filter bits not zero");
    a_sid_exact_match: assert property ( // [RULE3]
        rx_valid && hit[0] |-> rx_sid == sid_reg[0][CAF_SID_MSB:CAF_SID_LSB])
        else $error("filter 0 hit with unequal standard id");
    a_eid_exact_match: assert property ( // [RULE8]
        rx_valid && rx_ide && hit[0]
            |-> rx_eid == {sid_reg[0][1:0], eid_reg[0]})
        else $error("filter 0 hit with unequal extended id");
    a_type_ext_only: assert property ( // [RULE4]
        rx_valid && mte_reg && !rx_ide |-> (hit & type_vec) == '0)
        else $error("extended-type filter hit a standard frame");
    a_type_std_only: assert property ( // [RULE5]
        rx_valid && mte_reg && rx_ide |-> (hit & ~type_vec) == '0)
        else $error("standard-type filter hit an extended frame");
    a_enable_gates: assert property ( // [RULE17]
        (hit & ~fen_reg[NF-1:0]) == '0)
        else $error("disabled filter reported a hit");
    a_accept_once: assert property ( // [RULE19]
        take |=> rx_accept ##1 !rx_accept)
        else $error("accepted frame not pulsed once");
    a_dest_buffer: assert property ( // [RULE18]
        take |=> rx_buffer == {1'b0, $past(win_ptr)}
                 && (($past(hit) & ((16'h0001 << rx_filter) - 16'h0001))
                     == '0))
        else $error("wrong destination or not lowest filter");
    a_data_limit: assert property ( // [RULE20]
        st_reg == CAF_STORE |-> widx_reg <= 3'h6)
        else $error("more than eight data bytes stored");
    a_dlc_word: assert property ( // [RULE13] [RULE14]
        wr_go && widx_reg == CAF_BW_DLC
            |-> mem_bus.wdata[8] == 1'b0 && mem_bus.wdata[7:4] == 4'h0
                && mem_bus.wdata[3:0] == f_dlc_reg)
        else $error("length word stored wrongly");
    a_fen_readback: assert property ( // [RULE1]
        reg_rd && reg_addr == CAF_ADDR_FEN |=> reg_rdata == $past(fen_reg))
        else $error("enable register readback wrong");

    c_accept_ext: cover property (take && rx_ide);
    c_multi_hit: cover property (take && (hit & (hit - 16'h0001)) != '0);
    c_store_stall: cover property (st_reg == CAF_STORE && buf_acc);
    c_long_dlc: cover property (take && rx_dlc > CAF_MAX_DLC);
endmodule

// ### sim/caf_engine_model.sv
`timescale 1ns/100ps
// =====================================================
// protocol engine side: offers received frames
module caf_engine_model
    import caf_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rx_ready,
    output logic             rx_valid,
    output logic             rx_ide,
    output logic      [10:0] rx_sid,
    output logic      [17:0] rx_eid,
    output logic             rx_rtr,
    output logic      [3:0]  rx_dlc,
    output logic      [63:0] rx_data
);
    initial
    begin
        rx_valid = 1'b0;
        rx_ide   = 1'b0;
        rx_sid   = 11'h000;
        rx_eid   = 18'h0_0000;
        rx_rtr   = 1'b0;
        rx_dlc   = 4'h0;
        rx_data  = 64'h0000_0000_0000_0000;
    end

    // gap idles a few cycles first, so the engine is seen slow and quick
    task automatic send(input int gap, input logic ide,
                        input logic [10:0] standard_identifier_field, input logic [17:0] extended_identifier_field,
                        input logic rtr, input logic [3:0] dlc,
                        input logic [63:0] data, output logic ok);
        int n;
        repeat (gap) @(posedge clock);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_ide   <= ide;
        rx_sid   <= standard_identifier_field;
        rx_eid   <= extended_identifier_field;
        rx_rtr   <= rtr;
        rx_dlc   <= dlc;
        rx_data  <= data;
        n = 0;
        // ready is combinational, so look at it away from the edge
        do
        begin
            @(negedge clock);
            n++;
        end
        while (rx_ready !== 1'b1 && n < 64);
        @(posedge clock);
        rx_valid <= 1'b0;
        // released fields must not keep showing the old frame
        rx_ide   <= ~ide;
        rx_sid   <= ~standard_identifier_field;
        rx_eid   <= ~extended_identifier_field;
        rx_rtr   <= ~rtr;
        rx_dlc   <= ~dlc;
        rx_data  <= ~data;
        ok = (n < 64);
    endtask
endmodule

// ### sim/caf_top_bench.sv
`timescale 1ns/100ps
module caf_top_bench
    import caf_pkg::*;
();
    logic        clock;
    logic        rst_b;
    logic [8:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        rx_valid;
    logic        rx_ready;
    logic        rx_ide;
    logic [10:0] rx_sid;
    logic [17:0] rx_eid;
    logic        rx_rtr;
    logic [3:0]  rx_dlc;
    logic [63:0] rx_data;
    logic        rx_accept;
    logic [3:0]  rx_filter;
    logic [4:0]  rx_buffer;
    logic        ok;
    int          fails;
    int          checks;

    localparam logic [10:0] T_SID  = 11'h5a3;
    localparam logic [17:0] T_EID  = 18'h2_b3c4;
    localparam logic [3:0]  T_DLC  = 4'ha;
    localparam logic [63:0] T_DATA = 64'h8877_6655_4433_2211;
    localparam logic [21:0] TC [7] = '{
        {4'b0011, 18'h0_0000},  // type bit ignored with check off
        {4'b1010, 18'h0_0000},  // standard filter drops extended
        {4'b1111, 18'h0_0000},  // extended filter takes extended
        {4'b1100, 18'h0_0000},  // extended filter drops standard
        {4'b1001, 18'h0_0000},  // standard filter takes standard
        {4'b1110, 18'h0_0001},  // low extended bit differs
        {4'b1110, 18'h2_0000}}; // top extended bit differs

    caf_top #(.NF(16)) i_dut (.clock(clock), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_ide(rx_ide), .rx_sid(rx_sid),
        .rx_eid(rx_eid), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc),
        .rx_data(rx_data), .rx_accept(rx_accept), .rx_filter(rx_filter),
        .rx_buffer(rx_buffer));

    caf_engine_model i_eng (.clock(clock), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_ide(rx_ide), .rx_sid(rx_sid),
        .rx_eid(rx_eid), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc),
        .rx_data(rx_data));

    // =====================================================
    // clock and watchdog; reset is driven at the start of the tests
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        fails++;
        end_of_test();
    end

    // =====================================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [8:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic frame(input logic ide, input logic [10:0] standard_identifier_field,
                         input logic [17:0] extended_identifier_field, input logic acc,
                         input logic [3:0] flt, input logic [4:0] bnum);
        int n;
        i_eng.send(int'(standard_identifier_field[1:0]), ide, standard_identifier_field, extended_identifier_field, ~extended_identifier_field[0], T_DLC, T_DATA, ok);
        chk({15'h0000, ok}, 16'h0001);
        #1;
        chk({15'h0000, rx_accept}, {15'h0000, acc});
        if (acc)
        begin
            chk({12'h000, rx_filter}, {12'h000, flt});
            chk({11'h000, rx_buffer}, {11'h000, bnum});
        end
        @(posedge clock);
        #1;
        chk({15'h0000, rx_accept}, 16'h0000);
        n = 0;
        while (rx_ready !== 1'b1 && n < 40)
        begin
            @(negedge clock);
            n++;
        end
        chk({15'h0000, rx_ready}, 16'h0001);
    endtask

    task end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // =====================================================
    // tests
    initial
    begin
        fails = 0;
        checks = 0;
        rst_b <= 1'b0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= 9'h000;
        reg_wdata <= 16'h0000;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;

        rd(CAF_ADDR_FEN, 16'hffff);
        rd(CAF_ADDR_CTRL, 16'h0000);
        wr(CAF_ADDR_SID_BASE + 9'h00f, 16'hffff);
        rd(CAF_ADDR_SID_BASE + 9'h00f, 16'hffeb);
        wr(CAF_ADDR_EID_BASE + 9'h00f, 16'ha5c3);
        rd(CAF_ADDR_EID_BASE + 9'h00f, 16'ha5c3);
        rd(9'h030, 16'h0000);
        // software keeps both reserved protocol bits at zero
        wr(9'h1fa, 16'hfeef);
        rd(9'h1fa, 16'hfe0f);
        wr(9'h1fe, 16'hbeef);
        rd(9'h1fe, 16'hbeef);
        $display("test registers done");

        wr(CAF_ADDR_FEN, 16'h0000);
        wr(CAF_ADDR_SID_BASE + 9'h005, {T_SID, 5'h00});
        wr(CAF_ADDR_SID_BASE + 9'h009, {T_SID, 5'h00});
        wr(9'h022, 16'h0070);
        wr(9'h023, 16'h0020);
        rd(9'h022, 16'h0070);
        wr(CAF_ADDR_FEN, 16'h0220);
        wr(9'h13f, 16'h5a5a);
        frame(1'b0, T_SID, T_EID, 1'b1, 4'h5, 5'h07);
        rd(CAF_ADDR_STAT, {7'h00, 5'h07, 4'h5});
        rd(9'h138, {3'b000, T_SID, 2'b00});
        rd(9'h139, {4'h0, T_EID[17:6]});
        rd(9'h13a, {T_EID[5:0], ~T_EID[0], 5'h00, T_DLC});
        for (int w = 0; w < 4; w++)
            rd(9'h13b + 9'(w), T_DATA[16*w +: 16]);
        rd(9'h13f, 16'h5a5a);
        wr(CAF_ADDR_FEN, 16'h0200);
        frame(1'b0, T_SID, T_EID, 1'b1, 4'h9, 5'h02);
        frame(1'b0, T_SID ^ 11'h400, T_EID, 1'b0, 4'h0, 5'h00);
        frame(1'b0, T_SID ^ 11'h001, T_EID, 1'b0, 4'h0, 5'h00);
        $display("test acceptance done");

        wr(CAF_ADDR_EID_BASE + 9'h009, T_EID[15:0]);
        for (int i = 0; i < 7; i++)
        begin
            wr(CAF_ADDR_CTRL, {15'h0000, TC[i][21]});
            wr(CAF_ADDR_SID_BASE + 9'h009,
               {T_SID, 1'b0, TC[i][20], 1'b0, T_EID[17:16]});
            frame(TC[i][19], T_SID, T_EID ^ TC[i][17:0], TC[i][18],
                  4'h9, 5'h02);
        end
        $display("test type check done");
        end_of_test();
    end
endmodule
